// file: design/feac_rx_code.sv
// Purpose: Receive code queue, live and latched status, and host registers for one port
// Assumes: Codes arrive already validated, one cycle pulse per code
// Notes: Host reads return data in the cycle after the read strobe
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "feac_rx_params.svh"

// ----------------------------------------
// Code queue
// ----------------------------------------
module feac_code_queue #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
)(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } queue_state_s;

  queue_state_s state_reg;
  queue_state_s state_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    push = in_valid_i && (state_reg.count != (AW+1)'(DEPTH));
    pop = out_ready_i && (state_reg.count != '0);
    if (flush_i)
    begin
      // Flush beats both push and pop
      state_next.wr_ptr = '0;
      state_next.rd_ptr = '0;
      state_next.count = '0;
    end
    else
    begin
      if (push)
      begin
        state_next.mem[state_reg.wr_ptr] = in_data_i;
        state_next.wr_ptr = ptr_step(state_reg.wr_ptr);
      end
      if (pop)
      begin
        state_next.rd_ptr = ptr_step(state_reg.rd_ptr);
      end
      if (push && !pop)
      begin
        state_next.count = state_reg.count + 1'b1;
      end
      else if (pop && !push)
      begin
        state_next.count = state_reg.count - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Full is a state, so ready comes straight from the count
  assign in_ready_o = (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid_o = (state_reg.count != '0);
  assign out_data_o = state_reg.mem[state_reg.rd_ptr];
endmodule

// ----------------------------------------
// Receive code block top
// ----------------------------------------
module feac_rx_code #(
  parameter logic [1:0] PORT_INDEX = 2'h0,
  parameter int QUEUE_DEPTH = `RXC_QUEUE_DEPTH
)(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire feac_rx_pkg::rx_code_s rx_code_i,
  output logic rx_code_ready_o,
  input wire logic codeword_detect_i,
  input wire logic alarm_idle_i,
  input wire logic [3:0] global_port_irq_enables_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);

  typedef struct packed {
    logic rx_code_soft_reset;
    logic codeword_detect_live;
    logic alarm_idle_live;
    feac_rx_pkg::event_bits_s latched;
    feac_rx_pkg::event_bits_s irq_en;
    logic [15:0] rdata;
    logic irq;
    logic ready;
  } top_state_s;

  top_state_s state_reg;
  top_state_s state_next;
  logic q_in_ready;
  logic q_out_valid;
  logic [`RXC_CODE_WIDTH-1:0] q_out_data;
  logic q_pop;
  logic q_push;
  logic hit;
  logic [7:0] ofs;
  logic code_queue_empty;
  logic [15:0] rd_value;
  feac_rx_pkg::event_bits_s set_bits;
  feac_rx_pkg::event_bits_s clr_bits;

  // Port group base: high nibble 0, 2, 4, 6
  assign hit = (addr_i[11:8] == {1'b0, PORT_INDEX, 1'b0});
  assign ofs = addr_i[7:0];
  assign code_queue_empty = !q_out_valid;

  // Pops only while not held in soft reset
  assign q_pop = rd_i && hit && (ofs == `RXC_OFS_OUTPUT) && !state_reg.rx_code_soft_reset;
  // Incoming codes dropped during soft reset
  assign q_push = rx_code_i.valid && !state_reg.rx_code_soft_reset;

  // Depth is a parameter; a push while full is refused
  feac_code_queue #(
    .WIDTH(`RXC_CODE_WIDTH),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(state_reg.rx_code_soft_reset),
    .in_valid_i(q_push),
    .in_data_i(rx_code_i.code),
    .in_ready_o(q_in_ready),
    .out_valid_o(q_out_valid),
    .out_data_o(q_out_data),
    .out_ready_i(q_pop)
  );

  always_comb
  begin
    state_next = state_reg;
    rd_value = 16'h0000;
    set_bits = '0;
    clr_bits = '0;

    // Live status tracks the receiver indications
    state_next.codeword_detect_live = codeword_detect_i;
    state_next.alarm_idle_live = alarm_idle_i;

    // Rising edges and lost codes
    set_bits.detect = codeword_detect_i && !state_reg.codeword_detect_live;
    set_bits.idle = alarm_idle_i && !state_reg.alarm_idle_live;
    set_bits.overflow = q_push && !q_in_ready;

    // Read mux
    case (ofs)
      `RXC_OFS_CONTROL:
      begin
        rd_value = `RXC_CONTROL_FIXED;
        rd_value[`RXC_BIT_SOFT_RESET] = state_reg.rx_code_soft_reset;
      end
      `RXC_OFS_LIVE:
      begin
        rd_value[`RXC_BIT_EMPTY] = code_queue_empty;
        rd_value[`RXC_BIT_DETECT] = state_reg.codeword_detect_live;
        rd_value[`RXC_BIT_IDLE] = state_reg.alarm_idle_live;
      end
      `RXC_OFS_LATCHED:
      begin
        rd_value[2:0] = state_reg.latched;
      end
      `RXC_OFS_IRQ_EN:
      begin
        rd_value[2:0] = state_reg.irq_en;
      end
      `RXC_OFS_OUTPUT:
      begin
        // Invalid flag and code, first received bit at bit 0
        rd_value[`RXC_BIT_INVALID] = code_queue_empty;
        rd_value[`RXC_CODE_WIDTH-1:0] = code_queue_empty ? '0 : q_out_data;
      end
      default:
      begin
        rd_value = 16'h0000;
      end
    endcase

    // Data stands only in the cycle after the strobe
    state_next.rdata = (rd_i && hit) ? rd_value : 16'h0000;

    if (wr_i && hit)
    begin
      case (ofs)
        `RXC_OFS_CONTROL:
        begin
          state_next.rx_code_soft_reset = wdata_i[`RXC_BIT_SOFT_RESET];
        end
        `RXC_OFS_LATCHED:
        begin
          clr_bits = wdata_i[2:0];
        end
        `RXC_OFS_IRQ_EN:
        begin
          state_next.irq_en = wdata_i[2:0];
        end
        default:
        begin
          state_next.irq_en = state_reg.irq_en;
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    state_next.latched = (state_reg.latched & ~clr_bits) | set_bits;
    // Idle latch held set while soft reset is applied
    if (state_reg.rx_code_soft_reset)
    begin
      state_next.latched.idle = 1'b1;
    end

    state_next.irq = (|(state_next.latched & state_next.irq_en))
      && global_port_irq_enables_i[{PORT_INDEX}];
    // Ready lags the queue by one cycle; the overflow flag covers that edge
    state_next.ready = q_in_ready && !state_next.rx_code_soft_reset;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
      state_reg.latched <= `RXC_LATCHED_RESET;
      state_reg.irq_en <= `RXC_IRQ_EN_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign irq_o = state_reg.irq;
  assign rx_code_ready_o = state_reg.ready;
endmodule

// file: design/feac_rx_params.svh
// Purpose: Offsets, field positions, reset values and sizes for the receive code block
// Assumes: 12-bit byte address, 16-bit register data
// Notes: Included by bare name from the design file
//
// Notes on behaviour
// - While the soft reset bit is 1 the queue is emptied, pops stop and incoming codes are dropped.
// - When the soft reset bit goes back to 0 the block resumes normal code handling.
// - Live status bit 3 is 1 when the queue holds no code and 0 otherwise.
// - Live status bit 1 follows the codeword detect indication from the receiver.
// - Live status bit 0 follows the all-ones idle indication from the receiver.
// - A code arriving while the queue cannot take it is lost and sets latched bit 2.
// - A 0 to 1 change of live detect sets latched bit 1.
// - A 0 to 1 change of live idle sets latched bit 0.
// - After any reset the latched idle bit reads as 1.
// - The interrupt is raised only when a latched bit, its enable and this port's global enable are all set.
// - Bit 7 of the output register reads 1 when the queue is empty, 0 when the code is valid.
// - The code sits in bits 5..0, first received bit in bit 0, last in bit 5.
// - Reading the output register pops the queue so the next code shows afterwards.
// - The register group sits at a base with high nibble 0, 2, 4 or 6 for ports one to four.
`ifndef FEAC_RX_PARAMS_SVH
`define FEAC_RX_PARAMS_SVH

// ----------------------------------------
// Register offsets within the port group
// ----------------------------------------
`define RXC_OFS_CONTROL 8'hd0
`define RXC_OFS_LIVE 8'hd4
`define RXC_OFS_LATCHED 8'hd6
`define RXC_OFS_IRQ_EN 8'hd8
`define RXC_OFS_OUTPUT 8'hdc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXC_BIT_SOFT_RESET 0
`define RXC_BIT_EMPTY 3
`define RXC_BIT_DETECT 1
`define RXC_BIT_IDLE 0
`define RXC_BIT_OVERFLOW 2
`define RXC_BIT_INVALID 7

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define RXC_CONTROL_FIXED 16'h0800
`define RXC_LATCHED_RESET 3'h1
`define RXC_IRQ_EN_RESET 3'h0
`define RXC_CODE_WIDTH 6
`define RXC_QUEUE_DEPTH 16

`endif

// file: design/feac_rx_pkg.sv
// Purpose: Types shared by the receive code block
// Assumes: The 6-bit code width is written out here and must match RXC_CODE_WIDTH in feac_rx_params.svh
// Notes: Nothing here is imported; users write feac_rx_pkg::name
package feac_rx_pkg;

  // Code word handed over by the codeword validator
  typedef struct packed {
    logic valid;
    logic [5:0] code;
  } rx_code_s;

  // Latched event bits in register order (bit 2..0)
  typedef struct packed {
    logic overflow;
    logic detect;
    logic idle;
  } event_bits_s;

endpackage

// file: test/feac_code_source.sv
// Purpose: Model of the codeword validator feeding the block
// Assumes: Called from the bench just after a rising edge
// Notes: Code lines are inverted once on return to idle, with valid low, so stale codes never look valid
`timescale 1ns/1ps
module feac_code_source (
  input wire logic core_clk_i,
  output feac_rx_pkg::rx_code_s rx_code_o
);
  initial rx_code_o = '0;
  task automatic send(input logic [5:0] first, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_code_o <= '{1'b1, first + 6'(i)};
      @(posedge core_clk_i);
    end
    rx_code_o <= '{1'b0, ~rx_code_o.code};
  endtask
endmodule

// file: test/feac_rx_code_props.sv
// Purpose: Port assertions for feac_rx_code
// Assumes: One-cycle strobes, read data in the cycle after the read strobe
// Notes: Bound to every instance of the block below
`timescale 1ns/1ps
module feac_rx_code_props #(
  parameter logic [1:0] PORT_INDEX = 2'h0
)(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rx_code_ready_o,
  input wire logic codeword_detect_i,
  input wire logic alarm_idle_i,
  input wire logic [3:0] global_port_irq_enables_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_o
);
  logic hit;
  assign hit = addr_i[11:8] == {1'b0, PORT_INDEX, 1'b0};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(ofs);
    rd_i && hit && addr_i[7:0] == ofs;
  endsequence
  sequence s_soft_on;
    wr_i && hit && addr_i[7:0] == 8'hd0 && wdata_i[0];
  endsequence
  property p_soft_ready;
    s_soft_on |-> ##[1:2] !rx_code_ready_o;
  endproperty
  a_soft_ready: assert property (p_soft_ready) else $error("ready high in soft reset");
  property p_resume;
    $fell(sys_rst_i) |-> !rx_code_ready_o ##1 rx_code_ready_o;
  endproperty
  a_resume: assert property (p_resume) else $error("ready late after reset");
  property p_live_det;
    s_rd(8'hd4) |=> rdata_o[1] == $past(codeword_detect_i, 2);
  endproperty
  a_live_det: assert property (p_live_det) else $error("live detect wrong");
  property p_live_idle;
    s_rd(8'hd4) |=> rdata_o[0] == $past(alarm_idle_i, 2);
  endproperty
  a_live_idle: assert property (p_live_idle) else $error("live idle wrong");
  property p_irq_gate;
    irq_o |-> $past(global_port_irq_enables_i[PORT_INDEX]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without port enable");
  property p_out_field;
    s_rd(8'hdc) |=> rdata_o[15:8] == 8'h00 && !rdata_o[6];
  endproperty
  a_out_field: assert property (p_out_field) else $error("output spare bits set");
  property p_unmapped;
    s_rd(8'hd2) |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_other_port;
    rd_i && !hit |=> rdata_o == 16'h0000;
  endproperty
  a_other_port: assert property (p_other_port) else $error("foreign base answered");
endmodule

bind feac_rx_code feac_rx_code_props #(.PORT_INDEX(PORT_INDEX)) i_feac_rx_code_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rx_code_ready_o(rx_code_ready_o),
  .codeword_detect_i(codeword_detect_i), .alarm_idle_i(alarm_idle_i),
  .global_port_irq_enables_i(global_port_irq_enables_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// file: test/test_feac_rx_code.sv
// Purpose: Self-checking bench for feac_rx_code
// Assumes: Port index 0, queue depth 8
// Notes: Depth 8 keeps the overflow walk short
`timescale 1ns/1ps
module test_feac_rx_code;
  logic clk;
  logic rst = 1'b1;
  logic det = 1'b0;
  logic idl = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic irq;
  logic rdy;
  logic [3:0] gen = 4'h0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  feac_rx_pkg::rx_code_s code;
  int n_errors = 0;
  int tests_run = 0;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  feac_code_source i_feac_code_source (.core_clk_i(clk), .rx_code_o(code));
  feac_rx_code #(.QUEUE_DEPTH(8)) i_feac_rx_code (
    .core_clk_i(clk), .sys_rst_i(rst), .rx_code_i(code), .rx_code_ready_o(rdy),
    .codeword_detect_i(det), .alarm_idle_i(idl), .global_port_irq_enables_i(gen),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [11:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic get(input logic [11:0] a, input logic [15:0] exp);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic t_reset();
    get(12'h0d0, 16'h0800);
    get(12'h0d6, 16'h0001);
    get(12'h0d8, 16'h0000);
    get(12'h0d4, 16'h0008);
    get(12'h0dc, 16'h0080);
    get(12'h2d4, 16'h0000);
    get(12'h0d2, 16'h0000);
  endtask
  task automatic t_events();
    put(12'h0d6, 16'h0007);
    get(12'h0d6, 16'h0000);
    put(12'h0d8, 16'h0002);
    gen <= 4'h1;
    det <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(irq), 16'h0001);
    get(12'h0d4, 16'h000a);
    get(12'h0d6, 16'h0002);
    gen <= 4'h0;
    repeat (2) @(posedge clk);
    chk(16'(irq), 16'h0000);
    det <= 1'b0;
    idl <= 1'b1;
    repeat (3) @(posedge clk);
    get(12'h0d6, 16'h0003);
    get(12'h0d4, 16'h0009);
    idl <= 1'b0;
    put(12'h0d6, 16'h0007);
  endtask
  task automatic t_queue();
    i_feac_code_source.send(6'h21, 9);
    get(12'h0d4, 16'h0000);
    get(12'h0d6, 16'h0004);
    put(12'h0d6, 16'h0000);
    get(12'h0d6, 16'h0004);
    put(12'h0d6, 16'h0004);
    get(12'h0d6, 16'h0000);
    for (int i = 0; i < 8; i++)
      get(12'h0dc, {10'h000, 6'(6'h21 + i)});
    get(12'h0dc, 16'h0080);
    get(12'h0d4, 16'h0008);
  endtask
  task automatic t_soft();
    i_feac_code_source.send(6'h05, 2);
    put(12'h0d0, 16'h0001);
    chk(16'(rdy), 16'h0000);
    get(12'h0d4, 16'h0008);
    i_feac_code_source.send(6'h11, 1);
    get(12'h0dc, 16'h0080);
    put(12'h0d0, 16'h0000);
    chk(16'(rdy), 16'h0001);
    i_feac_code_source.send(6'h12, 1);
    get(12'h0dc, 16'h0012);
    get(12'h0dc, 16'h0080);
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_queue();
    t_soft();
    results();
  end
endmodule
